// file: src/irq_regs_params.svh
// offsets, field layouts, reset values and masks of the enable/priority block
`ifndef IRQ_REGS_PARAMS_SVH
`define IRQ_REGS_PARAMS_SVH

// ----------------------------------------------------------------------
// register word addresses (avalon word addressing)
// ----------------------------------------------------------------------
`define IRQ_ADDR_W 4
`define IRQ_OFS_EN2 4'h0
`define IRQ_OFS_EN3 4'h1
`define IRQ_OFS_EN4 4'h2
`define IRQ_OFS_PRIO0 4'h3
`define IRQ_OFS_PRIO1 4'h4
`define IRQ_OFS_PRIO2 4'h5
`define IRQ_OFS_FLAG2 4'h6
`define IRQ_OFS_FLAG3 4'h7
`define IRQ_OFS_FLAG4 4'h8
`define IRQ_OFS_FLAGP 4'h9

// ----------------------------------------------------------------------
// implemented bit masks
// ----------------------------------------------------------------------
`define IRQ_EN2_MASK 16'h0007
`define IRQ_EN3_MASK 16'h39ff
`define IRQ_EN4_MASK 16'h00f6
`define IRQ_PRIO_MASK 16'h7777
`define IRQ_FLAGP_MASK 16'h0fff

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IRQ_EN_RESET 16'h0000
`define IRQ_PRIO_RESET 16'h4444

// ----------------------------------------------------------------------
// priority field layout
// ----------------------------------------------------------------------
`define IRQ_PRIO_W 3
`define IRQ_PRIO_STRIDE 4
`define IRQ_PRIO_FIELDS 12
`define IRQ_PRIO_OFF 3'h0

`endif

// file: src/irq_regs_pkg.sv
// types of the enable/priority block
`include "irq_regs_params.svh"

package irq_regs_pkg;

   typedef struct packed {
      logic [15:0] en2;
      logic [15:0] en3;
      logic [15:0] en4;
      logic [15:0] prio0;
      logic [15:0] prio1;
      logic [15:0] prio2;
      logic [15:0] flag2;
      logic [15:0] flag3;
      logic [15:0] flag4;
      logic [15:0] flagp;
      logic [15:0] rd_clr;
      logic [3:0] rd_sel;
      logic waitrequest;
      logic [31:0] readdata;
      logic irq;
      logic [15:0] req2;
      logic [15:0] req3;
      logic [15:0] req4;
      logic [11:0] req_prio;
      logic [35:0] req_level;
   } regs_state_t;

endpackage

// file: src/irq_gate_if.sv
// carrier between the register file and the priority request gate
`timescale 1ns/1ps
`default_nettype none

interface irq_gate_if;
   logic [47:0] prio_all;
   logic [11:0] src_en;
   logic [11:0] flag;
   logic [11:0] req;
   logic [35:0] level;

   modport regs (output prio_all, output src_en, output flag, input req, input level);
   modport gate (input prio_all, input src_en, input flag, output req, output level);
endinterface

`default_nettype wire

// file: src/irq_prio_gate.sv
// per-source request gating by flag, enable and priority field
`timescale 1ns/1ps
`default_nettype none
`include "irq_regs_params.svh"

module irq_prio_gate #(
   parameter int FIELDS = `IRQ_PRIO_FIELDS
) (
   irq_gate_if.gate g
);

   genvar i;
   generate
      for (i = 0; i < FIELDS; i++) begin : g_src
         logic [2:0] lvl;
         // field i sits at bits i*4+2..i*4 of the three priority words
         assign lvl = g.prio_all[i*`IRQ_PRIO_STRIDE +: `IRQ_PRIO_W];
         // code 000 silences the source whatever its enable holds
         assign g.req[i] = g.flag[i] & g.src_en[i] & (lvl != `IRQ_PRIO_OFF);
         // level equals the code: 001 lowest, 111 highest
         assign g.level[i*3 +: 3] = lvl;
      end
   endgenerate

endmodule

`default_nettype wire

// file: src/irq_enable_priority_regs.sv
// interrupt enable and priority registers with avalon-mm slave and flags
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_regs_params.svh"

module irq_enable_priority_regs #(
   parameter int ADDR_W = `IRQ_ADDR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // source events, one-cycle pulses, bit layout as the enable words
   input wire logic [15:0] evt2,
   input wire logic [15:0] evt3,
   input wire logic [15:0] evt4,
   // priority-field source events and their enables held elsewhere
   input wire logic [11:0] evt_prio,
   input wire logic [11:0] prio_src_en,
   // register values towards arbitration
   output logic [15:0] enable_reg2,
   output logic [15:0] irq_enable_reg3,
   output logic [15:0] irq_enable_reg4,
   output logic [15:0] irq_priority_reg0,
   output logic [15:0] irq_priority_reg1,
   output logic [15:0] irq_priority_reg2,
   // gated requests towards arbitration
   output logic [15:0] req2,
   output logic [15:0] req3,
   output logic [15:0] req4,
   output logic [11:0] req_prio,
   output logic [35:0] req_level,
   // summary interrupt
   output logic irq
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   irq_regs_pkg::regs_state_t st_r;
   irq_regs_pkg::regs_state_t st_nxt;

   irq_gate_if gif ();

   irq_prio_gate #(
      .FIELDS(`IRQ_PRIO_FIELDS)
   ) u_gate (
      .g(gif.gate)
   );

   assign gif.prio_all = {st_r.prio2, st_r.prio1, st_r.prio0};
   assign gif.src_en = prio_src_en;
   assign gif.flag = st_r.flagp[11:0];

   // ----------------------------------------------------------------------
   // byte-lane write helper
   // ----------------------------------------------------------------------
   function automatic logic [15:0] lane_write(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] be,
      input logic [15:0] impl
   );
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}};
      lane_write = ((old & ~lanes) | (wd[15:0] & lanes)) & impl;
   endfunction

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   function automatic logic [15:0] read_word(
      input irq_regs_pkg::regs_state_t s,
      input logic [ADDR_W-1:0] a
   );
      case (a)
         `IRQ_OFS_EN2: read_word = s.en2;
         `IRQ_OFS_EN3: read_word = s.en3;
         `IRQ_OFS_EN4: read_word = s.en4;
         `IRQ_OFS_PRIO0: read_word = s.prio0;
         `IRQ_OFS_PRIO1: read_word = s.prio1;
         `IRQ_OFS_PRIO2: read_word = s.prio2;
         `IRQ_OFS_FLAG2: read_word = s.flag2;
         `IRQ_OFS_FLAG3: read_word = s.flag3;
         `IRQ_OFS_FLAG4: read_word = s.flag4;
         `IRQ_OFS_FLAGP: read_word = s.flagp;
         default: read_word = 16'h0000;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic req_on;
      logic accept;
      logic [15:0] clr2;
      logic [15:0] clr3;
      logic [15:0] clr4;
      logic [15:0] clrp;
      req_on = 1'b0;
      accept = 1'b0;
      clr2 = 16'h0000;
      clr3 = 16'h0000;
      clr4 = 16'h0000;
      clrp = 16'h0000;
      st_nxt = st_r;

      req_on = read | write;
      // the answer edge: waitrequest already low and the request still held
      accept = req_on & ~st_r.waitrequest;

      if (req_on & st_r.waitrequest) begin
         // one wait cycle, then data and waitrequest low together
         st_nxt.waitrequest = 1'b0;
         st_nxt.rd_sel = address;
         if (read) begin
            st_nxt.readdata = {16'h0000, read_word(st_r, address)};
            st_nxt.rd_clr = read_word(st_r, address);
         end else begin
            st_nxt.readdata = 32'h0000_0000;
            st_nxt.rd_clr = 16'h0000;
         end
      end else if (accept) begin
         st_nxt.waitrequest = 1'b1;
      end

      if (accept & write) begin
         case (address)
            `IRQ_OFS_EN2: st_nxt.en2 = lane_write(st_r.en2, writedata, byteenable,
                                                  `IRQ_EN2_MASK);
            `IRQ_OFS_EN3: st_nxt.en3 = lane_write(st_r.en3, writedata, byteenable,
                                                  `IRQ_EN3_MASK);
            `IRQ_OFS_EN4: st_nxt.en4 = lane_write(st_r.en4, writedata, byteenable,
                                                  `IRQ_EN4_MASK);
            `IRQ_OFS_PRIO0: st_nxt.prio0 = lane_write(st_r.prio0, writedata, byteenable,
                                                      `IRQ_PRIO_MASK);
            `IRQ_OFS_PRIO1: st_nxt.prio1 = lane_write(st_r.prio1, writedata, byteenable,
                                                      `IRQ_PRIO_MASK);
            `IRQ_OFS_PRIO2: st_nxt.prio2 = lane_write(st_r.prio2, writedata, byteenable,
                                                      `IRQ_PRIO_MASK);
            default: st_nxt.en2 = st_r.en2;
         endcase
      end

      // read of a flag word clears only the bits that were returned
      if (accept & read) begin
         case (st_r.rd_sel)
            `IRQ_OFS_FLAG2: clr2 = st_r.rd_clr;
            `IRQ_OFS_FLAG3: clr3 = st_r.rd_clr;
            `IRQ_OFS_FLAG4: clr4 = st_r.rd_clr;
            `IRQ_OFS_FLAGP: clrp = st_r.rd_clr;
            default: clr2 = 16'h0000;
         endcase
      end

      // sticky flags, a new event wins over a same-cycle clear
      st_nxt.flag2 = ((st_r.flag2 & ~clr2) | evt2) & `IRQ_EN2_MASK;
      st_nxt.flag3 = ((st_r.flag3 & ~clr3) | evt3) & `IRQ_EN3_MASK;
      st_nxt.flag4 = ((st_r.flag4 & ~clr4) | evt4) & `IRQ_EN4_MASK;
      st_nxt.flagp = ((st_r.flagp & ~clrp) | {4'h0, evt_prio}) & `IRQ_FLAGP_MASK;

      // req2..req4 gating uses the stored enables, so a change acts next cycle; prio_src_en goes to the gate unstored
      st_nxt.req2 = st_r.flag2 & st_r.en2;
      st_nxt.req3 = st_r.flag3 & st_r.en3;
      st_nxt.req4 = st_r.flag4 & st_r.en4;
      st_nxt.req_prio = gif.req;
      st_nxt.req_level = gif.level;
      st_nxt.irq = (|(st_r.flag2 & st_r.en2)) | (|(st_r.flag3 & st_r.en3)) |
                   (|(st_r.flag4 & st_r.en4)) | (|gif.req);
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.en2 <= `IRQ_EN_RESET;
         st_r.en3 <= `IRQ_EN_RESET;
         st_r.en4 <= `IRQ_EN_RESET;
         st_r.prio0 <= `IRQ_PRIO_RESET;
         st_r.prio1 <= `IRQ_PRIO_RESET;
         st_r.prio2 <= `IRQ_PRIO_RESET;
         st_r.waitrequest <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign readdata = st_r.readdata;
   assign waitrequest = st_r.waitrequest;
   assign enable_reg2 = st_r.en2;
   assign irq_enable_reg3 = st_r.en3;
   assign irq_enable_reg4 = st_r.en4;
   assign irq_priority_reg0 = st_r.prio0;
   assign irq_priority_reg1 = st_r.prio1;
   assign irq_priority_reg2 = st_r.prio2;
   assign req2 = st_r.req2;
   assign req3 = st_r.req3;
   assign req4 = st_r.req4;
   assign req_prio = st_r.req_prio;
   assign req_level = st_r.req_level;
   assign irq = st_r.irq;

endmodule

`default_nettype wire

// file: tb/irq_regs_props.sv
// assertion checker for the enable and priority register block
`timescale 1ns/1ps
`default_nettype none
`include "irq_regs_params.svh"
module irq_regs_props #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // bus
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // registers
   input wire logic [15:0] enable_reg2,
   input wire logic [15:0] irq_enable_reg3,
   input wire logic [15:0] irq_enable_reg4,
   input wire logic [15:0] irq_priority_reg0,
   input wire logic [15:0] irq_priority_reg1,
   input wire logic [15:0] irq_priority_reg2,
   // requests
   input wire logic [15:0] req2,
   input wire logic [15:0] req3,
   input wire logic [15:0] req4,
   input wire logic [11:0] req_prio,
   input wire logic [35:0] req_level,
   input wire logic irq
);
   logic [47:0] en_all;
   logic [47:0] pw;
   logic [35:0] code_r;
   logic lvl_bad;
   logic acc_w;
   assign en_all = {enable_reg2, irq_enable_reg3, irq_enable_reg4};
   assign pw = {irq_priority_reg2, irq_priority_reg1, irq_priority_reg0};
   assign acc_w = write && !waitrequest;
   // field codes as the gate saw them
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         code_r <= '0;
      end else begin
         for (int i = 0; i < 12; i++) code_r[3*i+:3] <= pw[4*i+:3];
      end
   end
   always_comb begin
      lvl_bad = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (req_prio[i] && (code_r[3*i+:3] == 3'h0 || req_level[3*i+:3] != code_r[3*i+:3])) begin
            lvl_bad = 1'b1;
         end
      end
   end
   // ---
   // properties
   // ---
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   reset_vals_a: assert property (
      $fell(rst) |-> en_all == 48'h0 && pw == {3{`IRQ_PRIO_RESET}}) else $error("bad reset value");
   unused_zero_a: assert property (
      readdata[31:16] == 16'h0 && (pw & ~{3{`IRQ_PRIO_MASK}}) == 48'h0
      && (en_all & ~{`IRQ_EN2_MASK, `IRQ_EN3_MASK, `IRQ_EN4_MASK}) == 48'h0)
      else $error("unused bit set");
   prio_write_a: assert property (
      acc_w && address == `IRQ_OFS_PRIO1 && byteenable[1:0] == 2'b11 |=>
      {16'h0, irq_priority_reg1} == ($past(writedata) & {16'h0, `IRQ_PRIO_MASK}))
      else $error("priority write lost");
   en_gate_a: assert property (({req2, req3, req4} & ~$past(en_all)) == 48'h0)
      else $error("disabled source requests");
   prio_gate_a: assert property (!lvl_bad)
      else $error("request level wrong");
   irq_sum_a: assert property (irq == |{req2, req3, req4, req_prio})
      else $error("irq not summary of requests");
   reg_hold_a: assert property (!acc_w |=> $stable(en_all) && $stable(pw))
      else $error("register changed without write");
   cover property ($rose(irq));
   cover property (req_prio[0] && req_level[2:0] == 3'h7);
   cover property (acc_w && address == `IRQ_OFS_PRIO1);
endmodule
bind irq_enable_priority_regs irq_regs_props #(.ADDR_W(ADDR_W)) u_irq_regs_props (.clock, .rst,
   .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .enable_reg2,
   .irq_enable_reg3, .irq_enable_reg4, .irq_priority_reg0, .irq_priority_reg1,
   .irq_priority_reg2, .req2, .req3, .req4, .req_prio, .req_level, .irq);
`default_nettype wire

// file: tb/irq_src_model.sv
// peripheral sources pulsing their event lines
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // command
   input wire logic fire,
   input wire logic [59:0] pat,
   // events
   output logic [15:0] evt2,
   output logic [15:0] evt3,
   output logic [15:0] evt4,
   output logic [11:0] evt_prio
);
   // one-cycle pulse per command
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {evt2, evt3, evt4, evt_prio} <= '0;
      end else begin
         {evt2, evt3, evt4, evt_prio} <= fire ? pat : 60'h0;
      end
   end
endmodule
`default_nettype wire

// file: tb/test_irq_enable_priority_regs.sv
// self-checking bench for the enable and priority register block
`timescale 1ns/1ps
`default_nettype none
`include "irq_regs_params.svh"
module test_irq_enable_priority_regs;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic fire = 1'b0;
   logic [3:0] address = 4'h0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [59:0] pat = 60'h0;
   logic [11:0] prio_src_en = 12'h0;
   logic [31:0] readdata;
   logic waitrequest, irq;
   logic [15:0] evt2, evt3, evt4, req2, req3, req4;
   logic [11:0] evt_prio, req_prio;
   logic [35:0] req_level;
   logic [15:0] en2_o, en3_o, en4_o, pr0_o, pr1_o, pr2_o;
   logic [15:0] m_r[10];
   logic [15:0] im[10] = '{`IRQ_EN2_MASK, `IRQ_EN3_MASK, `IRQ_EN4_MASK, `IRQ_PRIO_MASK,
      `IRQ_PRIO_MASK, `IRQ_PRIO_MASK, `IRQ_EN2_MASK, `IRQ_EN3_MASK, `IRQ_EN4_MASK, `IRQ_FLAGP_MASK};
   int fails = 0;
   int n_compared = 0;
   int seed = 32'he17b;
   int r;
   irq_enable_priority_regs u_irq_enable_priority_regs (.clock, .rst, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .evt2, .evt3, .evt4, .evt_prio,
      .prio_src_en, .enable_reg2(en2_o), .irq_enable_reg3(en3_o), .irq_enable_reg4(en4_o),
      .irq_priority_reg0(pr0_o), .irq_priority_reg1(pr1_o), .irq_priority_reg2(pr2_o),
      .req2, .req3, .req4,
      .req_prio, .req_level, .irq);
   irq_src_model u_irq_src_model (.clock, .rst, .fire, .pat, .evt2, .evt3, .evt4, .evt_prio);
   // ---
   // tasks
   // ---
   task automatic close_out;
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
      input logic [1:0] be);
      logic [15:0] m;
      int n;
      m = {{8{be[1]}}, {8{be[0]}}};
      n = 0;
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {16'($random(seed)), d};
      byteenable <= {2'b00, be};
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 40) begin
         fails++;
         $display("[ERR] %0t bus request not answered", $time);
         close_out();
      end
      if (wr && a < 4'h6) m_r[a] = (m_r[a] & ~(m & im[a])) | (d & m & im[a]);
      if (!wr) chk({32'h0, readdata}, {48'h0, a < 4'ha ? m_r[a] : 16'h0});
      if (!wr && a > 4'h5 && a < 4'ha) m_r[a] = 16'h0;
   endtask
   task automatic pulse(input logic [63:0] p);
      @(posedge clock);
      fire <= 1'b1;
      pat <= {p[63:16], p[11:0]};
      @(posedge clock);
      fire <= 1'b0;
      for (int i = 0; i < 4; i++) m_r[6+i] |= p[63-16*i-:16] & im[6+i];
      repeat (4) @(posedge clock);
   endtask
   task automatic chk_req;
      logic [47:0] q;
      logic [11:0] e;
      logic [35:0] lv, lvm;
      logic [2:0] c;
      q = {m_r[6] & m_r[0], m_r[7] & m_r[1], m_r[8] & m_r[2]};
      for (int i = 0; i < 12; i++) begin
         c = m_r[3+i/4][4*(i%4)+:3];
         e[i] = m_r[9][i] & prio_src_en[i] & (c != 3'h0);
         lv[3*i+:3] = e[i] ? c : 3'h0;
         lvm[3*i+:3] = {3{e[i]}};
      end
      chk({16'h0, req2, req3, req4}, {16'h0, q});
      chk({15'h0, irq, req_prio, req_level & lvm}, {15'h0, |{q, e}, e, lv});
      chk({en2_o, en3_o, en4_o, pr0_o}, {m_r[0], m_r[1], m_r[2], m_r[3]});
      chk({32'h0, pr1_o, pr2_o}, {32'h0, m_r[4], m_r[5]});
   endtask
   initial begin
      forever #2 clock = ~clock;
   end
   initial begin
      for (int i = 0; i < 10; i++) m_r[i] = (i > 2 && i < 6) ? `IRQ_PRIO_RESET : 16'h0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 12; a++) xfer(1'b0, 4'(a), 16'h0, 2'b11);
      repeat (40) begin
         r = $random(seed);
         xfer(1'b1, 4'($unsigned(r) % 12), r[27:12], r[31:30]);
      end
      for (int a = 0; a < 12; a++) xfer(1'b0, 4'(a), 16'h0, 2'b11);
      for (int c = 0; c < 8; c++) begin
         for (int a = 3; a < 6; a++) xfer(1'b1, 4'(a), 16'(c * 16'h1111), 2'b11);
         prio_src_en <= 12'($random(seed));
         pulse(64'h0fff);
         chk_req();
         xfer(1'b0, 4'h9, 16'h0, 2'b11);
      end
      prio_src_en <= 12'h0;
      for (int a = 0; a < 3; a++) xfer(1'b1, 4'(a), 16'($random(seed)), 2'b11);
      pulse(64'hffff_ffff_ffff_0000);
      chk_req();
      xfer(1'b1, 4'h1, 16'h0, 2'b11);
      repeat (2) @(posedge clock);
      chk_req();
      xfer(1'b1, 4'h1, 16'hffff, 2'b11);
      repeat (2) @(posedge clock);
      chk_req();
      for (int a = 6; a < 10; a++) xfer(1'b0, 4'(a), 16'h0, 2'b11);
      repeat (2) @(posedge clock);
      chk_req();
      close_out();
   end
endmodule
`default_nettype wire
